//--- rtl/spp_top.sv
/*
  Two-channel serial port: receive FIFO, channel engine and APB top.
  Assumes one pclk domain; line pins arrive asynchronous.
*/
// The implementer's own choices: the APB slave port and the address map.
`default_nettype none

module spp_fifo import spp_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int D = FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  logic full_q, vld_q, wr, rd;

  // Flags held in flops so both sides see registered handshakes
  assign wr = in_valid && !full_q;
  assign rd = vld_q && out_ready;
  assign cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
  assign in_ready = !full_q;
  assign out_valid = vld_q;
  assign out_data = mem[rp_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      full_q <= cnt_d == (AW+1)'(D);
      vld_q <= cnt_d != '0;
      if (wr) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + AW'(1);
      if (rd) rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + AW'(1);
    end
  end

  // Storage is data only, so no reset
  always_ff @(posedge pclk) begin
    if (wr) mem[wp_q] <= in_data;
  end
endmodule : spp_fifo

module spp_chan import spp_pkg::*; #(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [CTRL_W-1:0] cfg,
  input wire logic [TMO_W-1:0] cfg_tmo,
  input wire logic [LEN_W-1:0] cfg_len,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd,
  output logic rts_n,
  output logic chan_id,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  output logic [CNT_W-1:0] tx_cnt,
  output logic [CNT_W-1:0] rx_cnt,
  output logic [3:0] events
);
  localparam logic [MS_W-1:0] MS_CYC = MS_W'(CLK_HZ / MS_PER_S);
  logic cfg_en, cfg_d7, cfg_stop2, cfg_gw;
  logic [1:0] cfg_par, cfg_flow;
  logic [DIV_W-1:0] div;
  logic [2:0] nb;
  assign cfg_en = cfg[CF_EN];
  assign cfg_d7 = cfg[CF_D7];
  assign cfg_stop2 = cfg[CF_STOP2];
  assign cfg_par = cfg[CF_PAR+:2];
  assign cfg_flow = cfg[CF_FLOW+:2];
  assign cfg_gw = cfg[CF_GW];
  assign div = baud_div(cfg[CF_BAUD+:4], CLK_HZ);
  assign nb = cfg_d7 ? 3'h6 : 3'h7;

  // Pin synchronisers; logic reads only the second stage
  logic [1:0] rxs_q, ctss_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxs_q <= 2'h3;
      ctss_q <= 2'h3;
    end else begin
      rxs_q <= {rxs_q[0], rxd};
      ctss_q <= {ctss_q[0], cts_n};
    end
  end

  // Receiver, sampling mid-bit; only the first stop bit is checked
  spp_ln_st_t rs_q;
  logic [DIV_W-1:0] rc_q;
  logic [2:0] rb_q;
  logic [7:0] rsh_q;
  logic rp_q, rok_q, perr_q, ferr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_q <= S_IDLE;
      rc_q <= '0;
      rb_q <= '0;
      rsh_q <= '0;
      rp_q <= 1'b0;
      rok_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      rok_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      if (rc_q != '0) rc_q <= rc_q - DIV_W'(1);
      case (rs_q)
        S_IDLE: if (!rxs_q[1]) begin
          rc_q <= div >> 1;
          rs_q <= S_START;
        end
        S_START: if (rc_q == '0) begin
          rs_q <= rxs_q[1] ? S_IDLE : S_DATA;
          rc_q <= div - DIV_W'(1);
          rb_q <= '0;
          rsh_q <= '0;
          rp_q <= 1'b0;
        end
        S_DATA: if (rc_q == '0) begin
          rsh_q[rb_q] <= rxs_q[1];
          rp_q <= rp_q ^ rxs_q[1];
          rc_q <= div - DIV_W'(1);
          rb_q <= rb_q + 3'h1;
          if (rb_q == nb) rs_q <= (cfg_par == PAR_NONE) ? S_STOP : S_PAR;
        end
        S_PAR: if (rc_q == '0) begin
          rp_q <= rp_q ^ rxs_q[1] ^ (cfg_par == PAR_ODD);
          rc_q <= div - DIV_W'(1);
          rs_q <= S_STOP;
        end
        S_STOP: if (rc_q == '0) begin
          rs_q <= S_IDLE;
          if (!rxs_q[1]) ferr_q <= 1'b1;
          else if (cfg_par != PAR_NONE && rp_q) perr_q <= 1'b1;
          else rok_q <= 1'b1;
        end
        default: rs_q <= S_IDLE;
      endcase
      if (!cfg_en) begin
        rs_q <= S_IDLE;
        rok_q <= 1'b0;
      end
    end
  end

  // In-band pause characters are consumed, never queued
  logic fchar, arr, pause_q;
  assign fchar = cfg_flow == FLOW_SW && (rsh_q == CH_XON || rsh_q == CH_XOFF);
  assign arr = rok_q && !fchar;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pause_q <= 1'b0;
    else if (cfg_flow != FLOW_SW) pause_q <= 1'b0;
    else if (rok_q && fchar) pause_q <= rsh_q == CH_XOFF;
  end

  // Packer: one byte held back (three in gateway) so the last can be marked
  logic [7:0] hd_q [3];
  logic [1:0] hn_q, dep;
  logic [LEN_W-1:0] pk_q;
  logic [TMO_W-1:0] im_q;
  logic [MS_W-1:0] mt_q;
  logic endp_q, tmo_hit, do_end, hfull, push, f_rdy;
  assign dep = cfg_gw ? 2'h3 : 2'h1;
  assign tmo_hit = im_q >= cfg_tmo;
  assign do_end = !arr && hn_q != '0 && (endp_q || tmo_hit);
  assign hfull = hn_q >= dep;
  assign push = (arr || do_end) && hfull;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hn_q <= '0;
      pk_q <= '0;
      endp_q <= 1'b0;
      for (int i = 0; i < 3; i++) hd_q[i] <= '0;
    end else if (!cfg_en) begin
      hn_q <= '0;
      pk_q <= '0;
      endp_q <= 1'b0;
    end else if (arr) begin
      if (hfull) begin
        hd_q[0] <= hd_q[1];
        hd_q[1] <= hd_q[2];
        hd_q[dep-2'h1] <= rsh_q;
      end else begin
        hd_q[hn_q] <= rsh_q;
        hn_q <= hn_q + 2'h1;
      end
      if (pk_q + LEN_W'(1) >= cfg_len) begin
        endp_q <= 1'b1;
        pk_q <= '0;
      end else begin
        pk_q <= pk_q + LEN_W'(1);
      end
    end else if (do_end) begin
      // Gateway drops the two held check bytes here
      hn_q <= '0;
      pk_q <= '0;
      endp_q <= 1'b0;
    end
  end

  // Millisecond idle timer, restarted by every queued byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mt_q <= '0;
      im_q <= '0;
    end else if (arr) begin
      mt_q <= '0;
      im_q <= '0;
    end else if (mt_q == MS_CYC - MS_W'(1)) begin
      mt_q <= '0;
      if (im_q != '1) im_q <= im_q + TMO_W'(1);
    end else begin
      mt_q <= mt_q + MS_W'(1);
    end
  end

  spp_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) spp_fifo_inst (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_data({do_end, hd_q[0]}),
    .in_ready(f_rdy),
    .out_valid(rx_valid),
    .out_data({rx_last, rx_data}),
    .out_ready(rx_ready)
  );

  // Transmitter; gateway appends the check word after each last byte
  spp_ln_st_t ts_q;
  logic [DIV_W-1:0] tc_q;
  logic [2:0] tb_q;
  logic [7:0] tsh_q;
  logic [15:0] crc_q;
  logic [1:0] cph_q;
  logic tp_q, tst_q, txd_q, rdy_q, stall, take, tgo;
  assign stall = (cfg_flow == FLOW_SW && pause_q) || (cfg_flow == FLOW_HW && ctss_q[1]);
  assign take = rdy_q && tx_valid;
  assign tgo = ts_q == S_IDLE && cfg_en && (take || (cph_q != '0 && !stall));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_q <= S_IDLE;
      tc_q <= '0;
      tb_q <= '0;
      tsh_q <= '0;
      tp_q <= 1'b0;
      tst_q <= 1'b0;
      txd_q <= 1'b1;
      rdy_q <= 1'b0;
      crc_q <= CRC_INIT;
      cph_q <= '0;
    end else begin
      rdy_q <= 1'b0;
      if (tc_q != '0) tc_q <= tc_q - DIV_W'(1);
      case (ts_q)
        S_IDLE: if (tgo) begin
          ts_q <= S_START;
          txd_q <= 1'b0;
          tc_q <= div - DIV_W'(1);
          if (take) begin
            tsh_q <= tx_data;
            if (cfg_gw) crc_q <= crc_byte(crc_q, tx_data);
            if (cfg_gw && tx_last) cph_q <= 2'h1;
          end else begin
            tsh_q <= (cph_q == 2'h1) ? crc_q[7:0] : crc_q[15:8];
            cph_q <= (cph_q == 2'h1) ? 2'h2 : 2'h0;
            if (cph_q == 2'h2) crc_q <= CRC_INIT;
          end
        end else begin
          txd_q <= 1'b1;
          rdy_q <= cfg_en && cph_q == '0 && !stall;
        end
        S_START: if (tc_q == '0) begin
          ts_q <= S_DATA;
          txd_q <= tsh_q[0];
          tp_q <= tsh_q[0];
          tb_q <= '0;
          tc_q <= div - DIV_W'(1);
        end
        S_DATA: if (tc_q == '0) begin
          tc_q <= div - DIV_W'(1);
          if (tb_q == nb && cfg_par == PAR_NONE) begin
            ts_q <= S_STOP;
            txd_q <= 1'b1;
            tst_q <= cfg_stop2;
          end else if (tb_q == nb) begin
            ts_q <= S_PAR;
            txd_q <= tp_q ^ (cfg_par == PAR_ODD);
          end else begin
            tb_q <= tb_q + 3'h1;
            txd_q <= tsh_q[tb_q+3'h1];
            tp_q <= tp_q ^ tsh_q[tb_q+3'h1];
          end
        end
        S_PAR: if (tc_q == '0) begin
          ts_q <= S_STOP;
          txd_q <= 1'b1;
          tst_q <= cfg_stop2;
          tc_q <= div - DIV_W'(1);
        end
        S_STOP: if (tc_q == '0) begin
          if (tst_q) begin
            tst_q <= 1'b0;
            tc_q <= div - DIV_W'(1);
          end else begin
            ts_q <= S_IDLE;
          end
        end
        default: ts_q <= S_IDLE;
      endcase
      if (!cfg_en) begin
        ts_q <= S_IDLE;
        txd_q <= 1'b1;
        rdy_q <= 1'b0;
        cph_q <= '0;
        crc_q <= CRC_INIT;
      end
    end
  end
  assign txd = txd_q;
  assign tx_ready = rdy_q;

  // Counters, events, handshake and identity outputs
  logic [CNT_W-1:0] txc_q, rxc_q;
  logic [3:0] ev_q;
  logic rts_q, id_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_q <= '0;
      rxc_q <= '0;
      ev_q <= '0;
      rts_q <= 1'b1;
      id_q <= 1'b0;
    end else begin
      if (tgo) txc_q <= txc_q + CNT_W'(1);
      if (rok_q) rxc_q <= rxc_q + CNT_W'(1);
      ev_q <= {pause_q, push && !f_rdy, ferr_q, perr_q};
      rts_q <= !(cfg_en && (cfg_flow != FLOW_HW || f_rdy));
      id_q <= cfg[CF_ID];
    end
  end
  assign tx_cnt = txc_q;
  assign rx_cnt = rxc_q;
  assign events = ev_q;
  assign rts_n = rts_q;
  assign chan_id = id_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_off_quiet;
    !cfg_en |=> txd_q && !rdy_q && rs_q == S_IDLE;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled channel active");
  property p_start_bit;
    tgo |=> !txd_q && ts_q == S_START && txc_q == $past(txc_q) + CNT_W'(1);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");
  property p_two_stop;
    ts_q == S_STOP && tc_q == '0 && tst_q && cfg_en |=> ts_q == S_STOP && txd_q;
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("second stop lost");
  property p_hw_stall;
    cfg_flow == FLOW_HW && ctss_q[1] && !take |=> !rdy_q;
  endproperty
  a_hw_stall: assert property (p_hw_stall) else $error("ready while stopped");
  property p_len_end;
    cfg_en && arr && pk_q + LEN_W'(1) >= cfg_len ##1 !arr && cfg_en |=> hn_q == '0;
  endproperty
  a_len_end: assert property (p_len_end) else $error("length release late");
  property p_len_mark;
    cfg_en && arr && pk_q + LEN_W'(1) >= cfg_len |=> endp_q && pk_q == '0;
  endproperty
  a_len_mark: assert property (p_len_mark) else $error("length not seen");
  property p_empty;
    hn_q == '0 |-> !push;
  endproperty
  a_empty: assert property (p_empty) else $error("empty buffer pushed");
  property p_rxcnt;
    rok_q |=> rxc_q == $past(rxc_q) + CNT_W'(1);
  endproperty
  a_rxcnt: assert property (p_rxcnt) else $error("rx count missed");
endmodule : spp_chan

module spp_top import spp_pkg::*; #(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] rxd,
  input wire logic [1:0] cts_n,
  output logic [1:0] txd,
  output logic [1:0] rts_n,
  output logic [1:0] chan_id,
  input wire logic [1:0] net_tx_valid,
  input wire logic [15:0] net_tx_data,
  input wire logic [1:0] net_tx_last,
  output logic [1:0] net_tx_ready,
  output logic [1:0] net_rx_valid,
  output logic [15:0] net_rx_data,
  output logic [1:0] net_rx_last,
  input wire logic [1:0] net_rx_ready
);
  logic [CTRL_W-1:0] ctrl_q [2];
  logic [TMO_W-1:0] tmo_q [2];
  logic [LEN_W-1:0] len_q [2];
  logic [2:0] stat_q [2];
  logic [CNT_W-1:0] txc [2];
  logic [CNT_W-1:0] rxc [2];
  logic [3:0] ev [2];

  // Two identical channels; identity is a plain setting of each
  for (genvar g = 0; g < 2; g++) begin : g_ch
    spp_chan #(.CLK_HZ(CLK_HZ)) spp_chan_inst (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(ctrl_q[g]),
      .cfg_tmo(tmo_q[g]),
      .cfg_len(len_q[g]),
      .rxd(rxd[g]),
      .cts_n(cts_n[g]),
      .txd(txd[g]),
      .rts_n(rts_n[g]),
      .chan_id(chan_id[g]),
      .tx_valid(net_tx_valid[g]),
      .tx_data(net_tx_data[8*g+:8]),
      .tx_last(net_tx_last[g]),
      .tx_ready(net_tx_ready[g]),
      .rx_valid(net_rx_valid[g]),
      .rx_data(net_rx_data[8*g+:8]),
      .rx_last(net_rx_last[g]),
      .rx_ready(net_rx_ready[g]),
      .tx_cnt(txc[g]),
      .rx_cnt(rxc[g]),
      .events(ev[g])
    );
  end

  // APB decode; answer prepared in setup, so no wait states
  logic ch, ok_d, wr;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  assign ch = paddr[CH_BIT];
  always_comb begin
    rd_d = '0;
    ok_d = paddr[ADDR_W-1:CH_BIT+1] == '0;
    case (paddr[CH_BIT-1:0])
      OFF_CTRL: rd_d = 32'(ctrl_q[ch]);
      OFF_TMO: rd_d = 32'(tmo_q[ch]);
      OFF_LEN: rd_d = 32'(len_q[ch]);
      OFF_TXCNT: rd_d = txc[ch];
      OFF_RXCNT: rd_d = rxc[ch];
      OFF_STAT: rd_d = 32'({ev[ch][ST_PAUSE], stat_q[ch]});
      default: ok_d = 1'b0;
    endcase
  end
  assign wr = psel && penable && pready_q && pwrite && !pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel && !penable;
      if (psel && !penable) begin
        pslverr_q <= !ok_d;
        prdata_q <= pwrite ? 32'h0 : rd_d;
      end
    end
  end

  // Settings; length is clamped into its legal range on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        ctrl_q[c] <= CTRL_RST;
        tmo_q[c] <= TMO_RST;
        len_q[c] <= LEN_RST;
      end
    end else if (wr) begin
      if (paddr[CH_BIT-1:0] == OFF_CTRL) ctrl_q[ch] <= pwdata[CTRL_W-1:0];
      if (paddr[CH_BIT-1:0] == OFF_TMO) tmo_q[ch] <= pwdata[TMO_W-1:0];
      if (paddr[CH_BIT-1:0] == OFF_LEN) len_q[ch] <= clamp_len(pwdata);
    end
  end

  // Sticky errors; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) stat_q[c] <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr && ch == c[0] && paddr[CH_BIT-1:0] == OFF_STAT)
          stat_q[c] <= (stat_q[c] & ~pwdata[2:0]) | ev[c][2:0];
        else
          stat_q[c] <= stat_q[c] | ev[c][2:0];
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_setup_ready;
    psel && !penable |=> pready_q && pslverr_q == !$past(ok_d);
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  property p_stop_idle;
    !ctrl_q[0][CF_EN] ##1 !ctrl_q[0][CF_EN] |-> txd[0];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("disabled line driven low");
endmodule : spp_top
`default_nettype wire

//--- rtl/spp_pkg.sv
/*
  Constants, types and helpers for the two-channel serial port with
  receive packing. Assumes a single pclk domain at 200 MHz.
*/
// Behaviour
// - Two channels; each one's identity is set freely, duplicates allowed.
// - A disabled channel, the default, neither sends nor takes serial data.
// - Rate from eleven values, 300 to 230400 baud, default 115200.
// - Seven or eight data bits per character, default eight.
// - One or two stop bits, default one.
// - Parity none, odd or even; added on send, checked on receive.
// - Flow control none, in-band pause characters, or handshake lines.
// - Received bytes queue; packet released when the idle timeout elapses.
// - Packet length 1 to 3000, default 1200; release on reaching it.
// - Length release does not wait for the timeout; first one wins.
// - Transparent mode, the default, passes bytes unchanged.
// - Gateway mode converts field-bus framing between line and network.
`default_nettype none
package spp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CLK_HZ_DEF = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned BAUD_N = 11;
  localparam int unsigned BAUD_TAB [BAUD_N] = '{300, 600, 1200, 2400, 4800,
    9600, 19200, 38400, 57600, 115200, 230400};
  localparam logic [3:0] BAUD_SEL_DEF = 4'h9;
  localparam int DIV_W = 20;
  localparam int MS_W = 20;
  localparam int ADDR_W = 8;
  localparam int CH_BIT = 5;
  // Register offsets inside one channel window
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_TMO = 5'h04;
  localparam logic [4:0] OFF_LEN = 5'h08;
  localparam logic [4:0] OFF_TXCNT = 5'h0c;
  localparam logic [4:0] OFF_RXCNT = 5'h10;
  localparam logic [4:0] OFF_STAT = 5'h14;
  // Control word fields
  localparam int CF_EN = 0;
  localparam int CF_BAUD = 1;
  localparam int CF_D7 = 5;
  localparam int CF_STOP2 = 6;
  localparam int CF_PAR = 7;
  localparam int CF_FLOW = 9;
  localparam int CF_GW = 11;
  localparam int CF_ID = 12;
  localparam int CTRL_W = 13;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0012;
  localparam int TMO_W = 16;
  localparam logic [TMO_W-1:0] TMO_RST = 16'h0032;
  localparam int LEN_W = 12;
  localparam logic [LEN_W-1:0] LEN_RST = 12'h4b0;
  localparam logic [LEN_W-1:0] LEN_MIN = 12'h001;
  localparam logic [LEN_W-1:0] LEN_MAX = 12'hbb8;
  localparam int CNT_W = 32;
  // Status bits; low three are sticky, write one to clear
  localparam int ST_PERR = 0;
  localparam int ST_FERR = 1;
  localparam int ST_OVR = 2;
  localparam int ST_PAUSE = 3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] FLOW_SW = 2'h1;
  localparam logic [1:0] FLOW_HW = 2'h2;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 9;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_START = 5'h02, S_DATA = 5'h04, S_PAR = 5'h08, S_STOP = 5'h10
  } spp_ln_st_t;

  // Bit period in clocks; unknown selections fall back to the default rate
  function automatic logic [DIV_W-1:0] baud_div(input logic [3:0] sel,
                                               input int unsigned hz);
    int unsigned r;
    r = BAUD_TAB[BAUD_SEL_DEF];
    if (sel < BAUD_N) r = BAUD_TAB[sel];
    return DIV_W'(hz / r);
  endfunction : baud_div

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    return x;
  endfunction : crc_byte

  function automatic logic [LEN_W-1:0] clamp_len(input logic [31:0] v);
    if (v < 32'(LEN_MIN)) return LEN_MIN;
    if (v > 32'(LEN_MAX)) return LEN_MAX;
    return v[LEN_W-1:0];
  endfunction : clamp_len
endpackage : spp_pkg
`default_nettype wire

//--- sim/spp_line_dev.sv
/*
  Far-end serial device model for both lines: sends and checks frames.
  Assumes tasks are called right after a rising pclk edge.
*/
`default_nettype none
module spp_line_dev #(
  parameter int DIV = 10
) (
  input wire logic pclk,
  input wire logic [1:0] txd,
  output logic [1:0] rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle line level is mark
  initial rxd = 2'b11;
  // One bit time on our line
  task automatic tick(input int c, input logic v);
    rxd[c] <= v;
    repeat (DIV) @(posedge pclk);
  endtask : tick
  // Start, data LSB first, optional parity, stop bits
  task automatic send(input int c, input logic [7:0] b, input bit d7, input bit [1:0] p,
                      input bit s2);
    logic pb;
    pb = (d7 ? ^b[6:0] : ^b) ^ (p == 2'h1);
    tick(c, 1'b0);
    for (int i = 0; i < (d7 ? 7 : 8); i++) tick(c, b[i]);
    if (p != 2'h0) tick(c, pb);
    tick(c, 1'b1);
    if (s2) tick(c, 1'b1);
  endtask : send
  // Sample mid-bit; returns at the middle of the first stop bit
  task automatic recv(input int c, input bit d7, input bit [1:0] p, output logic [7:0] b,
                      output bit ok);
    int n;
    n = 0;
    b = 8'h00;
    while (txd[c] !== 1'b0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    repeat (DIV / 2) @(posedge pclk);
    ok = (txd[c] === 1'b0) && (n < 5000);
    for (int i = 0; i < (d7 ? 7 : 8); i++) begin
      repeat (DIV) @(posedge pclk);
      b[i] = txd[c];
    end
    if (p != 2'h0) begin
      repeat (DIV) @(posedge pclk);
      ok &= (txd[c] === (^b ^ (p == 2'h1)));
    end
    repeat (DIV) @(posedge pclk);
    ok &= (txd[c] === 1'b1);
  endtask : recv
endmodule : spp_line_dev
`default_nettype wire

//--- sim/serial_port_packer_tb.sv
/*
  Self-checking bench for spp_top over APB, line model and network streams.
  Assumes CLK_HZ 1152000: ten clocks a bit, 1152 clocks a millisecond.
*/
`default_nettype none
module serial_port_packer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ok;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] rxd, cts_n, txd, rts_n, chan_id, ntv, ntl, ntr, nrv, nrl, nrr;
  logic [15:0] ntd, nrd;
  logic [8:0] rxq[$];
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  spp_top #(.CLK_HZ(1152000)) spp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n),
    .chan_id(chan_id), .net_tx_valid(ntv), .net_tx_data(ntd), .net_tx_last(ntl),
    .net_tx_ready(ntr), .net_rx_valid(nrv), .net_rx_data(nrd), .net_rx_last(nrl),
    .net_rx_ready(nrr));
  spp_line_dev #(.DIV(10)) spp_line_dev_inst (.pclk(pclk), .txd(txd), .rxd(rxd));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Log bytes the network side takes on channel a; cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (nrv[0] && nrr[0]) rxq.push_back({nrl[0], nrd[7:0]});
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // APB master; holds the request until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic snd(input logic [7:0] d);
    spp_line_dev_inst.send(0, d, 1'b0, 2'h0, 1'b0);
  endtask : snd
  task automatic t_reset();
    chk({rts_n, txd}, 4'hf);
    rdc(8'h20, 32'h12);
    rdc(8'h24, 32'h32);
    rdc(8'h28, 32'h4b0);
    apb(1'b1, 8'h0c, 32'h5);
    rdc(8'h0c, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(er, 1'b1);
    snd(8'h55);
    repeat (20) @(posedge pclk);
    rdc(8'h10, 32'h0);
  endtask : t_reset
  // Length reached well before the 1 ms idle limit
  task automatic t_len();
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h00, 32'h13);
    nrr <= 2'b11;
    for (int i = 1; i < 4; i++) snd(8'h30 + 8'(i));
    repeat (20) @(posedge pclk);
    chk(rxq.size(), 3);
    chk({rxq[0], rxq[2]}, 18'h0_6333);
    rxq.delete();
    snd(8'h41);
    snd(8'h42);
    repeat (20) @(posedge pclk);
    chk(rxq.size(), 1);
    repeat (1300) @(posedge pclk);
    chk({rxq[0], rxq[1]}, 18'h0_8342);
    rxq.delete();
    rdc(8'h10, 32'h5);
  endtask : t_len
  // Stalled network side: buffer fills, refuses, then drains
  task automatic t_fill();
    apb(1'b1, 8'h08, 32'hbb8);
    nrr <= 2'b00;
    for (int i = 0; i < 10; i++) snd(8'h60 + 8'(i));
    repeat (1300) @(posedge pclk);
    rdc(8'h14, 32'h4);
    nrr <= 2'b11;
    repeat (20) @(posedge pclk);
    chk(rxq.size(), 8);
    chk({rxq[0], rxq[7]}, 18'h0_c067);
  endtask : t_fill
  // Network to line on channel b, one frame per format
  task automatic t_tx();
    bit [3:0] cf[4] = '{4'h0, 4'h5, 4'he, 4'ha};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h20, {23'h0, cf[i][1:0], cf[i][3], cf[i][2], 5'h13});
      fork
        spp_line_dev_inst.recv(1, cf[i][2], cf[i][1:0], b, ok);
        begin
          ntv[1] <= 1'b1;
          ntd[15:8] <= 8'hc5;
          do @(posedge pclk); while (ntr[1] !== 1'b1);
          ntv[1] <= 1'b0;
        end
      join
      chk({ok, b}, {1'b1, cf[i][2] ? 8'h45 : 8'hc5});
      repeat (30) @(posedge pclk);
    end
    rdc(8'h2c, 32'h4);
  endtask : t_tx
  task automatic t_flow_id();
    cts_n <= 2'b10;
    apb(1'b1, 8'h20, 32'h413);
    repeat (5) @(posedge pclk);
    chk(ntr[1], 1'b0);
    chk(rts_n[1], 1'b0);
    cts_n <= 2'b00;
    repeat (5) @(posedge pclk);
    chk(ntr[1], 1'b1);
    apb(1'b1, 8'h00, 32'h1013);
    apb(1'b1, 8'h20, 32'h1013);
    repeat (2) @(posedge pclk);
    chk(chan_id, 2'b11);
  endtask : t_flow_id
  // Gateway on channel b: one byte marked last, then its check word low, high
  task automatic t_gw();
    apb(1'b1, 8'h20, 32'h813);
    fork
      begin
        spp_line_dev_inst.recv(1, 1'b0, 2'h0, b, ok);
        chk({ok, b}, 9'h101);
        spp_line_dev_inst.recv(1, 1'b0, 2'h0, b, ok);
        chk({ok, b}, 9'h17e);
        spp_line_dev_inst.recv(1, 1'b0, 2'h0, b, ok);
        chk({ok, b}, 9'h180);
      end
      begin
        ntv[1] <= 1'b1;
        ntl[1] <= 1'b1;
        ntd[15:8] <= 8'h01;
        do @(posedge pclk); while (ntr[1] !== 1'b1);
        ntv[1] <= 1'b0;
      end
    join
  endtask : t_gw
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cts_n, ntv, ntd, ntl, nrr} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_len();
    t_fill();
    t_tx();
    t_flow_id();
    t_gw();
    print_verdict();
  end
endmodule : serial_port_packer_tb
`default_nettype wire
